// ---- pkg/mdv_map.vh ----
// constants for the multiply/divide unit: operation codes, field widths,
// pipeline depth and divide timing; safe to include more than once
`ifndef MDV_MAP_VH
`define MDV_MAP_VH

// operation codes on issue_op_in
`define MDV_OP_W 4
`define MDV_OP_MULTIPLY_TO_ACC 4'h0
`define MDV_OP_MULTIPLY_ADD_ACC 4'h1
`define MDV_OP_MULTIPLY_SUB_ACC 4'h2
`define MDV_OP_MULTIPLY_TO_GENERAL_REGISTER 4'h3
`define MDV_OP_DIVIDE_OP 4'h4
`define MDV_OP_READ_HIGH 4'h5
`define MDV_OP_READ_LOW 4'h6
`define MDV_OP_WRITE_HIGH 4'h7
`define MDV_OP_WRITE_LOW 4'h8
`define MDV_OP_DUAL_HALF_MAC 4'h9
`define MDV_OP_LAST 4'h9

// four accumulator pairs and the operation tag
`define MDV_ACC_PAIRS 4
`define MDV_ACC_SEL_W 2
`define MDV_TAG_W 5

// radix-4 booth array over a 32x32 operand pair
`define MDV_BOOTH_GROUPS 17
`define MDV_BOOTH_W 66

// multiply pipeline: result this many cycles after issue
`define MDV_MUL_LATENCY 5

// early-in skips by dividend width
`define MDV_DIV_FULL_ITER 6'h20
`define MDV_DIV_SKIP_8 6'h17
`define MDV_DIV_SKIP_16 6'h0f
`define MDV_DIV_SKIP_24 6'h07

// divide latency (= reissue interval), unsigned/signed, by width
`define MDV_DIV_LAT_U8 6'h0c
`define MDV_DIV_LAT_S8 6'h0e
`define MDV_DIV_LAT_U16 6'h14
`define MDV_DIV_LAT_S16 6'h16
`define MDV_DIV_LAT_U24 6'h1c
`define MDV_DIV_LAT_S24 6'h1e
`define MDV_DIV_LAT_U32 6'h24
`define MDV_DIV_LAT_S32 6'h26

`endif

// ---- hdl/mdv_divider.v ----
// iterative restoring divider, one quotient bit per clock, early-in skip
// assumes start_in is only raised while idle; owner holds result until done
`timescale 1ns/1ps
`include "mdv_map.vh"

module mdv_divider (
   input wire core_clk_in,
   input wire rst_b_in,
   input wire start_in,
   input wire signed_in,
   input wire [31:0] dividend_in,
   input wire [31:0] divisor_in,
   output wire done_out,
   output wire [31:0] quotient_out,
   output wire [31:0] remainder_out
);
   reg [31:0] rem_reg;
   reg [31:0] quo_reg;
   reg [31:0] dvs_reg;
   reg [5:0] iter_reg;
   reg [5:0] cnt_reg;
   reg run_reg;
   reg neg_q_reg;
   reg neg_r_reg;
   reg [5:0] skip_next;
   reg [5:0] lat_next;
   wire [31:0] abs_dividend;
   wire [31:0] abs_divisor;
   wire [32:0] shifted;
   wire [32:0] trial;
   wire fits8;
   wire fits16;
   wire fits24;

   // magnitudes for signed mode, signs restored at the end
   assign abs_dividend = (signed_in && dividend_in[31]) ? (32'h0 - dividend_in) : dividend_in;
   assign abs_divisor = (signed_in && divisor_in[31]) ? (32'h0 - divisor_in) : divisor_in;

   // early-in: sign extension of the raw dividend
   assign fits8 = signed_in ? (&dividend_in[31:7] | ~|dividend_in[31:7]) : ~|dividend_in[31:8]; // [RL7]
   assign fits16 = signed_in ? (&dividend_in[31:15] | ~|dividend_in[31:15]) : ~|dividend_in[31:16]; // [RL7]
   assign fits24 = signed_in ? (&dividend_in[31:23] | ~|dividend_in[31:23]) : ~|dividend_in[31:24]; // [RL7]

   // skip count and latency for this width
   always @* begin
      if (fits8) begin
         skip_next = `MDV_DIV_SKIP_8; // [RL7]
         lat_next = signed_in ? `MDV_DIV_LAT_S8 : `MDV_DIV_LAT_U8; // [RL10]
      end else if (fits16) begin
         skip_next = `MDV_DIV_SKIP_16; // [RL7]
         lat_next = signed_in ? `MDV_DIV_LAT_S16 : `MDV_DIV_LAT_U16; // [RL10]
      end else if (fits24) begin
         skip_next = `MDV_DIV_SKIP_24; // [RL7]
         lat_next = signed_in ? `MDV_DIV_LAT_S24 : `MDV_DIV_LAT_U24; // [RL10]
      end else begin
         skip_next = 6'h00;
         lat_next = signed_in ? `MDV_DIV_LAT_S32 : `MDV_DIV_LAT_U32; // [RL10]
      end
   end

   // restoring step: shift in the next dividend bit, try the subtract
   assign shifted = {rem_reg, quo_reg[31]};
   assign trial = shifted - {1'b0, dvs_reg};

   // iterations end early; the counter pads out to the fixed latency
   always @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         rem_reg <= 32'h0;
         quo_reg <= 32'h0;
         dvs_reg <= 32'h0;
         iter_reg <= 6'h00;
         cnt_reg <= 6'h00;
         run_reg <= 1'b0;
         neg_q_reg <= 1'b0;
         neg_r_reg <= 1'b0;
      end else if (start_in) begin
         rem_reg <= 32'h0;
         quo_reg <= abs_dividend << skip_next; // [RL7]
         dvs_reg <= abs_divisor;
         iter_reg <= `MDV_DIV_FULL_ITER - skip_next; // [RL7]
         cnt_reg <= lat_next - 6'h02; // [RL10]
         run_reg <= 1'b1;
         neg_q_reg <= signed_in & (dividend_in[31] ^ divisor_in[31]);
         neg_r_reg <= signed_in & dividend_in[31];
      end else if (run_reg) begin
         if (iter_reg != 6'h00) begin
            rem_reg <= trial[32] ? shifted[31:0] : trial[31:0]; // [RL6]
            quo_reg <= {quo_reg[30:0], ~trial[32]}; // [RL6]
            iter_reg <= iter_reg - 6'h01;
         end
         if (cnt_reg == 6'h00) begin
            run_reg <= 1'b0;
         end else begin
            cnt_reg <= cnt_reg - 6'h01;
         end
      end
   end

   assign done_out = run_reg && (cnt_reg == 6'h00);
   assign quotient_out = neg_q_reg ? (32'h0 - quo_reg) : quo_reg;
   assign remainder_out = neg_r_reg ? (32'h0 - rem_reg) : rem_reg;
endmodule // mdv_divider

// ---- hdl/mdv_unit.v ----
// multiply/divide unit: five-stage multiply pipe, four accumulator pairs
// and an iterative divider; assumes the integer pipeline shares the clock
// and holds issues while div_busy_out is high
//
// How it works
// RL1: own pipeline keeps advancing; it never waits on integer pipeline stalls.
// RL2: multiplier is a radix-4 booth array over full 32-bit operands.
// RL3: four high/low accumulator pairs, targeted by multiply, add and subtract ops.
// RL4: a new multiply or multiply-accumulate is accepted every single cycle.
// RL5: signal-processing dual halfword multiply-add runs in the same pipeline.
// RL6: division makes one quotient bit per clock in a state machine.
// RL7: dividend sign extension skips 23, 15 or 7 iterations for 8/16/24 bits.
// RL8: issues while a divide runs are held off until the divide completes.
// RL9: multiply results arrive five cycles after issue, reissue every cycle.
// RL10: divide latency equals reissue interval, 12/14 up to 36/38 cycles.
// RL11: busy shows while dividing; the issuer holds further operations until it drops.
`timescale 1ns/1ps
`include "mdv_map.vh"

module mdv_unit (
   input wire core_clk_in,
   input wire rst_b_in,
   input wire issue_valid_in,
   input wire [3:0] issue_op_in,
   input wire [1:0] issue_acc_in,
   input wire issue_signed_in,
   input wire [4:0] issue_tag_in,
   input wire [31:0] first_source_operand_in,
   input wire [31:0] second_source_operand_in,
   output reg result_valid_out,
   output reg [4:0] result_tag_out,
   output reg [31:0] result_high_out,
   output reg [31:0] result_low_out,
   output reg div_busy_out
);
   // accumulator pairs, addressed by the pair index
   reg [31:0] result_high_reg [0:`MDV_ACC_PAIRS-1];
   reg [31:0] result_low_reg [0:`MDV_ACC_PAIRS-1];

   // stage 1: captured operands
   reg s1_valid_reg;
   reg [3:0] s1_op_reg;
   reg [1:0] s1_acc_reg;
   reg [4:0] s1_tag_reg;
   reg s1_signed_reg;
   reg [31:0] s1_a_reg;
   reg [31:0] s1_b_reg;

   // stage 2: product
   reg s2_valid_reg;
   reg [3:0] s2_op_reg;
   reg [1:0] s2_acc_reg;
   reg [4:0] s2_tag_reg;
   reg [31:0] s2_a_reg;
   reg [63:0] s2_prod_reg;

   // stage 3 and 4: result in flight after accumulator update
   reg s3_valid_reg;
   reg [4:0] s3_tag_reg;
   reg [63:0] s3_res_reg;
   reg s4_valid_reg;
   reg [4:0] s4_tag_reg;
   reg [63:0] s4_res_reg;

   // divide bookkeeping
   reg [1:0] div_acc_reg;
   reg [4:0] div_tag_reg;

   wire accept;
   wire op_known;
   wire div_start;
   wire div_done;
   wire [31:0] div_quotient;
   wire [31:0] div_remainder;

   // booth array signals
   wire [65:0] mcand_ext;
   wire [34:0] mplier_ext;
   wire [`MDV_BOOTH_GROUPS*`MDV_BOOTH_W-1:0] pp_flat;
   reg [65:0] booth_sum;
   wire signed [31:0] dsp_prod_hi;
   wire signed [31:0] dsp_prod_lo;
   wire [63:0] dsp_sum;
   reg [63:0] product_next;

   // stage 3 accumulator update
   reg [63:0] acc_cur;
   reg [63:0] acc_next;
   reg acc_we;
   integer k;
   integer j;

   // an issue is taken only when no divide is running [RL8]
   assign op_known = (issue_op_in <= `MDV_OP_LAST);
   assign accept = issue_valid_in && op_known && !div_busy_out; // [RL8] [RL11]
   assign div_start = accept && (issue_op_in == `MDV_OP_DIVIDE_OP);

   // stage 1 capture; no stall input exists, so the pipe always advances [RL1]
   always @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         s1_valid_reg <= 1'b0;
         s1_op_reg <= `MDV_OP_MULTIPLY_TO_ACC;
         s1_acc_reg <= 2'h0;
         s1_tag_reg <= 5'h00;
         s1_signed_reg <= 1'b0;
         s1_a_reg <= 32'h0;
         s1_b_reg <= 32'h0;
      end else begin
         s1_valid_reg <= accept && !div_start; // [RL4] [RL1]
         s1_op_reg <= issue_op_in;
         s1_acc_reg <= issue_acc_in;
         s1_tag_reg <= issue_tag_in;
         s1_signed_reg <= issue_signed_in;
         s1_a_reg <= first_source_operand_in;
         s1_b_reg <= second_source_operand_in;
      end
   end

   // operands: 66-bit multiplicand, 34-bit multiplier plus a zero below
   assign mcand_ext = {{34{s1_signed_reg & s1_a_reg[31]}}, s1_a_reg}; // [RL2]
   assign mplier_ext = {{2{s1_signed_reg & s1_b_reg[31]}}, s1_b_reg, 1'b0}; // [RL2]

   // radix-4 booth partial products, one per 2-bit group [RL2]
   genvar g;
   generate
      for (g = 0; g < `MDV_BOOTH_GROUPS; g = g + 1) begin : booth_grp
         wire [2:0] win;
         reg [65:0] sel;
         assign win = mplier_ext[2*g+2:2*g];
         always @* begin
            case (win)
               3'h1, 3'h2: sel = mcand_ext;
               3'h3: sel = mcand_ext << 1;
               3'h4: sel = 66'h0 - (mcand_ext << 1);
               3'h5, 3'h6: sel = 66'h0 - mcand_ext;
               default: sel = 66'h0;
            endcase
         end
         assign pp_flat[g*`MDV_BOOTH_W +: `MDV_BOOTH_W] = sel << (2*g); // [RL2]
      end
   endgenerate

   // partial product reduction; a plain adder chain, left for synthesis to tree
   always @* begin
      booth_sum = 66'h0;
      for (k = 0; k < `MDV_BOOTH_GROUPS; k = k + 1) begin
         booth_sum = booth_sum + pp_flat[k*`MDV_BOOTH_W +: `MDV_BOOTH_W]; // [RL2]
      end
   end

   // dual signed halfword products for the signal-processing extension [RL5]
   assign dsp_prod_hi = $signed(s1_a_reg[31:16]) * $signed(s1_b_reg[31:16]);
   assign dsp_prod_lo = $signed(s1_a_reg[15:0]) * $signed(s1_b_reg[15:0]);
   assign dsp_sum = {{32{dsp_prod_hi[31]}}, dsp_prod_hi} + {{32{dsp_prod_lo[31]}}, dsp_prod_lo}; // [RL5]

   // pick the product that stage 2 will hold
   always @* begin
      if (s1_op_reg == `MDV_OP_DUAL_HALF_MAC) begin
         product_next = dsp_sum; // [RL5]
      end else begin
         product_next = booth_sum[63:0];
      end
   end

   // stage 2 register
   always @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         s2_valid_reg <= 1'b0;
         s2_op_reg <= `MDV_OP_MULTIPLY_TO_ACC;
         s2_acc_reg <= 2'h0;
         s2_tag_reg <= 5'h00;
         s2_a_reg <= 32'h0;
         s2_prod_reg <= 64'h0;
      end else begin
         s2_valid_reg <= s1_valid_reg; // [RL1]
         s2_op_reg <= s1_op_reg;
         s2_acc_reg <= s1_acc_reg;
         s2_tag_reg <= s1_tag_reg;
         s2_a_reg <= s1_a_reg;
         s2_prod_reg <= product_next;
      end
   end

   // stage 3: read-modify-write of the pair, one stage after the product, so
   // back-to-back accumulates see each other without forwarding
   always @* begin
      acc_cur = {result_high_reg[s2_acc_reg], result_low_reg[s2_acc_reg]};
      acc_next = acc_cur;
      acc_we = 1'b0;
      case (s2_op_reg)
         `MDV_OP_MULTIPLY_TO_ACC: begin
            acc_next = s2_prod_reg; // [RL3]
            acc_we = 1'b1;
         end
         `MDV_OP_MULTIPLY_ADD_ACC, `MDV_OP_DUAL_HALF_MAC: begin
            acc_next = acc_cur + s2_prod_reg; // [RL3] [RL5]
            acc_we = 1'b1;
         end
         `MDV_OP_MULTIPLY_SUB_ACC: begin
            acc_next = acc_cur - s2_prod_reg; // [RL3]
            acc_we = 1'b1;
         end
         `MDV_OP_MULTIPLY_TO_GENERAL_REGISTER: begin
            acc_next = s2_prod_reg; // result only, pair left alone
         end
         `MDV_OP_WRITE_HIGH: begin
            acc_next = {s2_a_reg, acc_cur[31:0]};
            acc_we = 1'b1;
         end
         `MDV_OP_WRITE_LOW: begin
            acc_next = {acc_cur[63:32], s2_a_reg};
            acc_we = 1'b1;
         end
         default: begin
            acc_next = acc_cur; // read high / read low return the pair
         end
      endcase
   end

   // pairs: written by stage 3 or a finished divide, never both in one cycle,
   // as nothing issues while a divide runs
   always @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         for (j = 0; j < `MDV_ACC_PAIRS; j = j + 1) begin
            result_high_reg[j] <= 32'h0;
            result_low_reg[j] <= 32'h0;
         end
      end else if (s2_valid_reg && acc_we) begin
         result_high_reg[s2_acc_reg] <= acc_next[63:32]; // [RL3]
         result_low_reg[s2_acc_reg] <= acc_next[31:0]; // [RL3]
      end else if (div_done) begin
         result_high_reg[div_acc_reg] <= div_remainder;
         result_low_reg[div_acc_reg] <= div_quotient;
      end
   end

   // stages 3 and 4 carry the result to the five-cycle point
   always @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         s3_valid_reg <= 1'b0;
         s3_tag_reg <= 5'h00;
         s3_res_reg <= 64'h0;
         s4_valid_reg <= 1'b0;
         s4_tag_reg <= 5'h00;
         s4_res_reg <= 64'h0;
      end else begin
         s3_valid_reg <= s2_valid_reg; // [RL9]
         s3_tag_reg <= s2_tag_reg;
         s3_res_reg <= acc_next;
         s4_valid_reg <= s3_valid_reg; // [RL9]
         s4_tag_reg <= s3_tag_reg;
         s4_res_reg <= s3_res_reg;
      end
   end

   // divider runs on its own while the multiply pipe drains [RL6]
   mdv_divider u_divider (
      .core_clk_in(core_clk_in),
      .rst_b_in(rst_b_in),
      .start_in(div_start),
      .signed_in(issue_signed_in),
      .dividend_in(first_source_operand_in),
      .divisor_in(second_source_operand_in),
      .done_out(div_done),
      .quotient_out(div_quotient),
      .remainder_out(div_remainder)
   );

   // busy from the cycle after a divide is taken until its result shows
   always @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         div_busy_out <= 1'b0;
         div_acc_reg <= 2'h0;
         div_tag_reg <= 5'h00;
      end else if (div_start) begin
         div_busy_out <= 1'b1; // [RL11] [RL8]
         div_acc_reg <= issue_acc_in;
         div_tag_reg <= issue_tag_in;
      end else if (div_done) begin
         div_busy_out <= 1'b0; // [RL10] [RL11]
      end
   end

   // result port: multiply pipe at stage 5, or the divide on completion
   always @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         result_valid_out <= 1'b0;
         result_tag_out <= 5'h00;
         result_high_out <= 32'h0;
         result_low_out <= 32'h0;
      end else if (s4_valid_reg) begin
         result_valid_out <= 1'b1; // [RL9]
         result_tag_out <= s4_tag_reg;
         result_high_out <= s4_res_reg[63:32];
         result_low_out <= s4_res_reg[31:0];
      end else if (div_done) begin
         result_valid_out <= 1'b1; // [RL10]
         result_tag_out <= div_tag_reg;
         result_high_out <= div_remainder;
         result_low_out <= div_quotient;
      end else begin
         result_valid_out <= 1'b0;
      end
   end
endmodule // mdv_unit

// ---- bench/mdv_unit_sva.sv ----
// checker for the multiply/divide unit ports
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps

module mdv_unit_sva (
   input wire core_clk_in,
   input wire rst_b_in,
   input wire issue_valid_in,
   input wire [3:0] issue_op_in,
   input wire [1:0] issue_acc_in,
   input wire issue_signed_in,
   input wire [4:0] issue_tag_in,
   input wire [31:0] first_source_operand_in,
   input wire [31:0] second_source_operand_in,
   input wire result_valid_out,
   input wire [4:0] result_tag_out,
   input wire [31:0] result_high_out,
   input wire [31:0] result_low_out,
   input wire div_busy_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_b_in);

   // issues the unit takes; busy refuses all
   wire op_ok = issue_valid_in && !div_busy_out && (issue_op_in <= 4'h9);
   wire div_issue = op_ok && (issue_op_in == 4'h4);
   wire acc_issue = op_ok && (issue_op_in != 4'h4);
   wire refused = issue_valid_in && div_busy_out;
   wire [31:0] d = first_source_operand_in;
   wire s = issue_signed_in;
   // dividend width from its sign extension
   wire f8 = s ? (&d[31:7] | ~|d[31:7]) : ~|d[31:8];
   wire f16 = s ? (&d[31:15] | ~|d[31:15]) : ~|d[31:16];
   wire f24 = s ? (&d[31:23] | ~|d[31:23]) : ~|d[31:24];
   wire [5:0] base = f8 ? 6'h0c : f16 ? 6'h14 : f24 ? 6'h1c : 6'h24;
   wire [5:0] lat_now = base + {4'h0, s, 1'b0};
   reg [5:0] exp_len_reg;
   reg [5:0] run_len_reg;

   // divide length, counted only while busy so an early drop shows
   always @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         exp_len_reg <= 6'h00;
         run_len_reg <= 6'h00;
      end else if (div_issue) begin
         exp_len_reg <= lat_now;
         run_len_reg <= 6'h01;
      end else if (div_busy_out) begin
         run_len_reg <= run_len_reg + 6'h01;
      end
   end

   sequence s_acc_issue;
      acc_issue;
   endsequence
   sequence s_div_issue;
      div_issue;
   endsequence
   sequence s_div_end;
      $fell(div_busy_out);
   endsequence

   chk_mul_latency: assert property (s_acc_issue |-> ##5 result_valid_out)
      else $error("no multiply result at cycle five");
   chk_mul_back2back: assert property (s_acc_issue ##1 s_acc_issue |-> ##4 result_valid_out [*2])
      else $error("back to back multiplies lost a result");
   chk_tag_return: assert property (s_acc_issue |-> ##5 (result_tag_out == $past(issue_tag_in, 5)))
      else $error("result tag differs from issue tag");
   chk_busy_start: assert property (s_div_issue |=> div_busy_out)
      else $error("busy not raised after divide issue");
   chk_div_length: assert property (s_div_end |-> (run_len_reg == exp_len_reg) && result_valid_out)
      else $error("divide length wrong for width");
   chk_busy_bound: assert property ($rose(div_busy_out) |-> ##[11:37] !div_busy_out)
      else $error("busy outlasts longest divide");
   chk_refused_drop: assert property (refused |-> ##5 (!result_valid_out || $fell(div_busy_out)))
      else $error("refused issue gave a result");
   chk_no_stray: assert property (result_valid_out |-> ($past(acc_issue, 5) || $fell(div_busy_out)))
      else $error("result without matching issue");
endmodule // mdv_unit_sva

bind mdv_unit mdv_unit_sva u_sva (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
   .issue_valid_in(issue_valid_in), .issue_op_in(issue_op_in), .issue_acc_in(issue_acc_in),
   .issue_signed_in(issue_signed_in), .issue_tag_in(issue_tag_in),
   .first_source_operand_in(first_source_operand_in), .second_source_operand_in(second_source_operand_in),
   .result_valid_out(result_valid_out), .result_tag_out(result_tag_out), .result_high_out(result_high_out),
   .result_low_out(result_low_out), .div_busy_out(div_busy_out));

// ---- bench/mdv_issuer_model.sv ----
// model of the issuing integer pipeline: one queued request a cycle
// assumes busy rises one cycle after a divide issue
`timescale 1ns/1ps

module mdv_issuer_model (
   input wire core_clk_in,
   input wire rst_b_in,
   input wire stall_in,
   input wire rude_in,
   input wire div_busy_in,
   output reg issue_valid_out,
   output reg [3:0] issue_op_out,
   output reg [1:0] issue_acc_out,
   output reg issue_signed_out,
   output reg [4:0] issue_tag_out,
   output reg [31:0] first_source_operand_out,
   output reg [31:0] second_source_operand_out
);
   logic [75:0] req_q [$];
   logic [75:0] head;
   reg just_div_reg;

   initial begin
      {issue_valid_out, issue_op_out, issue_acc_out, issue_signed_out, issue_tag_out} = 13'h0;
      {first_source_operand_out, second_source_operand_out} = 64'h0;
      just_div_reg = 1'b0;
   end

   task automatic push(input logic [3:0] op, input logic [1:0] acc, input logic sgn,
      input logic [4:0] tag, input logic [31:0] a, input logic [31:0] b);
      req_q.push_back({op, acc, sgn, tag, a, b});
   endtask

   // busy is a cycle late, so a divide blocks the next slot
   always @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         req_q.delete();
         issue_valid_out <= 1'b0;
         just_div_reg <= 1'b0;
      end else if (req_q.size() > 0 && !stall_in && (rude_in || (!div_busy_in && !just_div_reg))) begin
         head = req_q.pop_front();
         issue_valid_out <= 1'b1;
         {issue_op_out, issue_acc_out, issue_signed_out, issue_tag_out} <= head[75:64];
         {first_source_operand_out, second_source_operand_out} <= head[63:0];
         just_div_reg <= (head[75:72] == 4'h4);
      end else begin
         // idle operands toggle so stale data cannot pass
         issue_valid_out <= 1'b0;
         just_div_reg <= 1'b0;
         first_source_operand_out <= ~first_source_operand_out;
         second_source_operand_out <= ~second_source_operand_out;
      end
   end
endmodule // mdv_issuer_model

// ---- bench/testbench.sv ----
// self-checking bench for the multiply/divide unit
// assumes outputs are settled by the falling edge
`timescale 1ns/1ps

module testbench;
   reg core_clk_in = 1'b0;
   reg rst_b_in = 1'b0;
   reg stall = 1'b0;
   reg rude = 1'b0;
   wire iv, isg, rv, busy;
   wire [3:0] iop;
   wire [1:0] iacc;
   wire [4:0] itag, rtag;
   wire [31:0] opa, opb, rhi, rlo;
   logic [68:0] res_q [$];
   integer busy_run = 0;
   integer bad_count = 0;
   integer n_checks = 0;

   always #4 core_clk_in = ~core_clk_in;

   mdv_issuer_model u_issuer (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .stall_in(stall),
      .rude_in(rude), .div_busy_in(busy), .issue_valid_out(iv), .issue_op_out(iop),
      .issue_acc_out(iacc), .issue_signed_out(isg), .issue_tag_out(itag),
      .first_source_operand_out(opa), .second_source_operand_out(opb));
   mdv_unit u_dut (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .issue_valid_in(iv),
      .issue_op_in(iop), .issue_acc_in(iacc), .issue_signed_in(isg), .issue_tag_in(itag),
      .first_source_operand_in(opa), .second_source_operand_in(opb), .result_valid_out(rv),
      .result_tag_out(rtag), .result_high_out(rhi), .result_low_out(rlo), .div_busy_out(busy));

   // collect results and busy cycles off the edge
   always @(negedge core_clk_in) begin
      if (rv === 1'b1)
         res_q.push_back({rtag, rhi, rlo});
      if (busy === 1'b1)
         busy_run = busy_run + 1;
   end

   task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks = n_checks + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic tally_and_finish;
      if (bad_count == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic put(input logic [3:0] op, input logic [1:0] acc, input logic sgn,
      input logic [4:0] tag, input logic [31:0] a, input logic [31:0] b);
      u_issuer.push(op, acc, sgn, tag, a, b);
   endtask

   // next result in order; sel picks the halves
   task automatic take(input logic [4:0] tag, input logic [31:0] hi, input logic [31:0] lo,
      input logic [1:0] sel);
      logic [68:0] r;
      integer k;
      for (k = 0; k < 80 && res_q.size() == 0; k = k + 1)
         @(negedge core_clk_in);
      if (res_q.size() == 0) begin
         check_val("result arrival", 32'h1, 32'h0);
         tally_and_finish;
      end
      r = res_q.pop_front();
      check_val("tag", {27'h0, tag}, {27'h0, r[68:64]});
      if (sel[1])
         check_val("high", hi, r[63:32]);
      if (sel[0])
         check_val("low", lo, r[31:0]);
   endtask

   task automatic do_reset;
      @(posedge core_clk_in);
      rst_b_in <= 1'b0;
      repeat (8) @(posedge core_clk_in);
      rst_b_in <= 1'b1;
      @(negedge core_clk_in);
      res_q.delete();
      check_val("busy at reset", 32'h0, {31'h0, busy});
      check_val("valid at reset", 32'h0, {31'h0, rv});
      check_val("high at reset", 32'h0, rhi);
   endtask

   // one burst: every op code but divide, all four pairs, one unknown op
   task automatic s_accumulate;
      @(negedge core_clk_in);
      put(4'h7, 2'h1, 1'b0, 5'h01, 32'h1, 32'h0);
      put(4'h8, 2'h1, 1'b0, 5'h02, 32'h10, 32'h0);
      put(4'h0, 2'h2, 1'b1, 5'h03, 32'hffffffff, 32'h3);
      put(4'h3, 2'h0, 1'b0, 5'h04, 32'hffffffff, 32'hffffffff);
      put(4'h9, 2'h3, 1'b1, 5'h05, 32'h0002fffd, 32'h00040005);
      put(4'hf, 2'h0, 1'b0, 5'h1f, 32'h5, 32'h5);
      put(4'h3, 2'h0, 1'b1, 5'h06, 32'hffff8000, 32'h00010000);
      put(4'h1, 2'h1, 1'b0, 5'h07, 32'hffffffff, 32'h2);
      put(4'h2, 2'h1, 1'b0, 5'h08, 32'h7, 32'h2);
      put(4'h5, 2'h0, 1'b0, 5'h09, 32'h0, 32'h0);
      put(4'h6, 2'h2, 1'b0, 5'h0a, 32'h0, 32'h0);
      put(4'h3, 2'h0, 1'b0, 5'h0b, 32'h00010000, 32'h00010000);
      put(4'h5, 2'h1, 1'b0, 5'h0c, 32'h0, 32'h0);
      take(5'h01, 32'h0, 32'h0, 2'b00);
      take(5'h02, 32'h0, 32'h0, 2'b00);
      take(5'h03, 32'hffffffff, 32'hfffffffd, 2'b11);
      take(5'h04, 32'hfffffffe, 32'h00000001, 2'b11);
      take(5'h05, 32'hffffffff, 32'hfffffff9, 2'b11);
      take(5'h06, 32'hffffffff, 32'h80000000, 2'b11);
      take(5'h07, 32'h3, 32'he, 2'b11);
      take(5'h08, 32'h3, 32'h0, 2'b11);
      take(5'h09, 32'h0, 32'h0, 2'b10);
      take(5'h0a, 32'h0, 32'hfffffffd, 2'b01);
      take(5'h0b, 32'h1, 32'h0, 2'b11);
      take(5'h0c, 32'h3, 32'h0, 2'b10);
   endtask

   task automatic div_one(input logic [31:0] a, input logic [31:0] b, input logic sgn,
      input logic [31:0] lat, input logic [31:0] q, input logic [31:0] r);
      @(negedge core_clk_in);
      busy_run = 0;
      put(4'h4, 2'h2, sgn, 5'h10, a, b);
      take(5'h10, r, q, 2'b11);
      check_val("busy cycles", lat - 32'h1, busy_run);
   endtask

   task automatic s_divide;
      div_one(32'h64, 32'h7, 1'b0, 32'hc, 32'he, 32'h2);
      div_one(32'h1234, 32'h10, 1'b0, 32'h14, 32'h123, 32'h4);
      div_one(32'h123456, 32'h100, 1'b0, 32'h1c, 32'h1234, 32'h56);
      div_one(32'h80000000, 32'h3, 1'b0, 32'h24, 32'h2aaaaaaa, 32'h2);
      div_one(32'hffffff9c, 32'h7, 1'b1, 32'he, 32'hfffffff2, 32'hfffffffe);
      div_one(32'hffff8000, 32'h100, 1'b1, 32'h16, 32'hffffff80, 32'h0);
      div_one(32'h00400000, 32'h10, 1'b1, 32'h1e, 32'h00040000, 32'h0);
      div_one(32'h7fffffff, 32'hfffffffe, 1'b1, 32'h26, 32'hc0000001, 32'h1);
      div_one(32'h5, 32'h0, 1'b0, 32'hc, 32'h1ff, 32'h5);
   endtask

   // issuer stalls; the unit still finishes
   task automatic s_stall;
      @(negedge core_clk_in);
      put(4'h0, 2'h0, 1'b0, 5'h14, 32'h6, 32'h7);
      put(4'h1, 2'h0, 1'b0, 5'h15, 32'h1, 32'h1);
      @(negedge core_clk_in);
      stall = 1'b1;
      take(5'h14, 32'h0, 32'h2a, 2'b11);
      repeat (2) @(negedge core_clk_in);
      check_val("queue held", 32'h0, res_q.size());
      stall = 1'b0;
      take(5'h15, 32'h0, 32'h2b, 2'b11);
   endtask

   // rude issue in a divide is dropped; a polite one waits
   task automatic s_refuse;
      @(negedge core_clk_in);
      rude = 1'b1;
      put(4'h4, 2'h3, 1'b0, 5'h16, 32'h64, 32'h7);
      put(4'h0, 2'h0, 1'b0, 5'h17, 32'h2, 32'h2);
      take(5'h16, 32'h2, 32'he, 2'b11);
      rude = 1'b0;
      put(4'h6, 2'h0, 1'b0, 5'h18, 32'h0, 32'h0);
      take(5'h18, 32'h0, 32'h2b, 2'b01);
      put(4'h4, 2'h1, 1'b0, 5'h19, 32'h64, 32'h7);
      put(4'h6, 2'h1, 1'b0, 5'h1a, 32'h0, 32'h0);
      take(5'h19, 32'h2, 32'he, 2'b11);
      take(5'h1a, 32'h0, 32'he, 2'b01);
   endtask

   // reset mid divide clears pairs and pending result
   task automatic s_midreset;
      @(negedge core_clk_in);
      put(4'h4, 2'h1, 1'b0, 5'h1b, 32'h80000000, 32'h3);
      repeat (6) @(negedge core_clk_in);
      do_reset;
      put(4'h6, 2'h1, 1'b0, 5'h1c, 32'h0, 32'h0);
      take(5'h1c, 32'h0, 32'h0, 2'b01);
   endtask

   initial begin
      do_reset;
      s_accumulate;
      s_divide;
      s_stall;
      s_refuse;
      s_midreset;
      repeat (10) @(negedge core_clk_in);
      check_val("stray results", 32'h0, res_q.size());
      tally_and_finish;
   end
endmodule // testbench
